// ===== wdg_pkg.sv
// Constants and carriers shared by the watchdog downcounter.
// Assumes one oscillator clock that also runs the CPU core.
package wdg_pkg;
   // Data-space address of the watchdog register.
   localparam logic [7:0]  WDG_COUNT_CONTROL_ADDR = 8'hd8;
   // Register image after chip reset.
   localparam logic [7:0]  WDG_RESET_IMAGE        = 8'hfe;
   // Field positions inside the register image.
   localparam int          WDG_ACTIVATE_BIT       = 0;
   localparam int          WDG_SOFT_RESET_BIT     = 1;
   localparam int          WDG_PERIOD_MSB_POS     = 2;
   localparam int          WDG_PERIOD_LSB_POS     = 7;
   // Physical counter: bit 6 is the soft-reset bit, bits 5..0 the period.
   localparam logic [6:0]  WDG_COUNT_RESET        = 7'h7f;
   localparam logic [6:0]  WDG_COUNT_LAST_SAFE    = 7'h40;
   // Oscillator cycles per counter step.
   localparam int          WDG_STEP_CYCLES        = 3072;
   localparam logic [11:0] WDG_PRESC_LAST         = 12'(WDG_STEP_CYCLES - 1);
   localparam logic [11:0] WDG_PRESC_RESET        = 12'h000;
   localparam logic [7:0]  WDG_UNMAPPED_READ      = 8'h00;

   // Core power state.
   typedef enum logic [1:0] {
      PWR_RUN,
      PWR_WAIT,
      PWR_STOP
   } wdg_pwr_e;

   // One data-space access from the core.
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } wdg_bus_req_s;

   // Option bits fixed when the device is programmed.
   typedef struct packed {
      logic hw_activation;
      logic ext_stop_ctrl;
   } wdg_opt_s;
endpackage

// ===== wdg_downcounter.sv
// Digital watchdog downcounter with its data-space register and stop/wait
// handling. Assumes the chip reset generator feeds wdg_reset_out back into
// rst_n_in, and that the core pulses stop/wait when it executes those.
// Function
// [R1] Reset image: disabled, longest period.
// [R2] Soft-reset bit falling issues chip reset.
// [R3] Register bit order reversed against counter.
// [R4] Six period bits give 64 timeout choices.
// [R5] Counter steps every 3072 oscillator cycles.
// [R6] Hardware option forces activation bit high.
// [R7] Software activation sticks until chip reset.
// [R8] Disabled counter works as 7-bit timer.
// [R9] At least 28 instructions before timeout.
// [R10] Software reloads within 27 instructions.
// [R11] Start-up code disables unexpected activation.
// [R12] Interrupts disabled: no wake from stop/wait.
// [R13] Board keeps interrupt pin high for stop.
// [R14] Hardware option without control: stop acts as wait.
// [R15] Stop with pin high freezes counter.
// [R16] Counter resumes from frozen value after stop.
module wdg_downcounter
   import wdg_pkg::*;
(
   input  wire logic         clk_sys_in,
   input  wire logic         rst_n_in,
   input  wire wdg_bus_req_s bus_req_in,
   input  wire wdg_opt_s     opt_in,
   input  wire logic         nmi_pin_in,
   input  wire logic         nmi_req_in,
   input  wire logic         irq_req_in,
   input  wire logic         global_irq_enable_in,
   input  wire logic         stop_instr_in,
   input  wire logic         wait_instr_in,
   output logic [7:0]        rdata_out,
   output logic              wdg_reset_out,
   output logic              stop_mode_out,
   output logic              wait_mode_out,
   output logic              wake_out,
   output logic              nmi_service_out
);
   logic [6:0]  count;
   logic        activate;
   logic [11:0] presc;
   wdg_pwr_e    pwr;
   logic        active;
   logic        wr_hit;
   logic        rd_hit;
   logic        step;
   logic        fall_by_write;
   logic        fall_by_count;
   logic        stop_allowed;
   logic        wake;
   logic [7:0]  image;
   logic [6:0]  wr_count;

   // Address decode and effective activation.
   assign wr_hit = bus_req_in.wr && (bus_req_in.addr == WDG_COUNT_CONTROL_ADDR);
   assign rd_hit = bus_req_in.rd && (bus_req_in.addr == WDG_COUNT_CONTROL_ADDR);
   // [R6] Hardware option forced.
   assign active = activate || opt_in.hw_activation;

   // [R3] Reversed bit mapping.
   generate
      for (genvar i = 0; i < 7; i++) begin : g_map
         assign image[WDG_PERIOD_LSB_POS - i] = count[i];
         assign wr_count[i] = bus_req_in.wdata[WDG_PERIOD_LSB_POS - i];
      end
   endgenerate
   assign image[WDG_ACTIVATE_BIT] = active;

   // [R5] Step on prescaler wrap.
   assign step = (presc == WDG_PRESC_LAST) && (pwr != PWR_STOP);

   // [R2] Soft-reset bit falls by write or, when running, by count.
   assign fall_by_write = wr_hit && count[6] && !bus_req_in.wdata[WDG_SOFT_RESET_BIT];
   // [R8] Timer mode never resets on rollover.
   assign fall_by_count = !wr_hit && step && active && (count == WDG_COUNT_LAST_SAFE);

   // [R14] Stop only when watchdog off or pin high under external control.
   assign stop_allowed = !active || (opt_in.ext_stop_ctrl && nmi_pin_in);
   // [R12] Wake only while interrupts are globally enabled.
   assign wake = (irq_req_in || nmi_req_in) && global_irq_enable_in;

   // Prescaler; restarted by every register write, so that an activation or a
   // reload always starts a full step whatever the phase was before it.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         presc <= WDG_PRESC_RESET;
      end else if (wr_hit) begin
         // [R9] Full step after activation or reload.
         presc <= WDG_PRESC_RESET;
      end else if (step) begin
         presc <= WDG_PRESC_RESET;
      end else if (pwr != PWR_STOP) begin
         presc <= presc + 12'h001;
      end
   end

   // Physical downcounter; a write reloads it and wins over a step.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         // [R1] Longest period after reset.
         count <= WDG_COUNT_RESET;
      end else if (wr_hit) begin
         // [R4] Period bits loaded from the write.
         count <= wr_count;
      end else if (step) begin
         // [R15] Frozen in stop, resumes afterwards.
         count <= count - 7'h01;
      end
   end

   // Activation bit; software can only set it.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         activate <= 1'b0;
      end else if (wr_hit && bus_req_in.wdata[WDG_ACTIVATE_BIT]) begin
         // [R7] Set-only activation.
         activate <= 1'b1;
      end
   end

   // Chip reset request, raised on the same edge as the soft-reset bit falls.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         wdg_reset_out <= 1'b0;
      end else begin
         wdg_reset_out <= fall_by_write || fall_by_count;
      end
   end

   // Register read data.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         rdata_out <= WDG_UNMAPPED_READ;
      end else if (rd_hit) begin
         rdata_out <= image;
      end else if (bus_req_in.rd) begin
         rdata_out <= WDG_UNMAPPED_READ;
      end
   end

   // Power state of the core as seen by the watchdog.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         pwr <= PWR_RUN;
      end else begin
         unique case (pwr)
            PWR_RUN: begin
               if (stop_instr_in && stop_allowed) begin
                  pwr <= PWR_STOP;
               end else if (stop_instr_in || wait_instr_in) begin
                  pwr <= PWR_WAIT;
               end
            end
            PWR_WAIT, PWR_STOP: begin
               // [R16] Leave on an enabled interrupt.
               if (wake) begin
                  pwr <= PWR_RUN;
               end
            end
         endcase
      end
   end

   // Mode flags and interrupt hand-off.
   assign stop_mode_out   = (pwr == PWR_STOP);
   assign wait_mode_out   = (pwr == PWR_WAIT);
   assign wake_out        = (pwr != PWR_RUN) && wake;
   // [R12] Serviced in run even with interrupts disabled.
   assign nmi_service_out = (pwr == PWR_RUN) && nmi_req_in;

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);

   // Checks on the watchdog behaviour.
   reset_image_a: assert property ( // [R1]
      !$past(rst_n_in) |-> (count == WDG_COUNT_RESET) && !activate)
      else $error("watchdog register not at reset image");
   write_reset_a: assert property ( // [R2]
      fall_by_write |=> wdg_reset_out)
      else $error("soft-reset write did not reset");
   bit_order_a: assert property ( // [R3]
      rd_hit |=> rdata_out[7] == $past(count[0]) && rdata_out[2] == $past(count[5])
                 && rdata_out[1] == $past(count[6]))
      else $error("register bit order wrong");
   timeout_reset_a: assert property ( // [R4]
      (active && step && !wr_hit && count == 7'h40) |=> wdg_reset_out ##1 !wdg_reset_out)
      else $error("timeout did not reset");
   step_period_a: assert property ( // [R5]
      (!$past(wr_hit) && count != $past(count)) |-> $past(presc) == WDG_PRESC_LAST)
      else $error("counter stepped off prescaler wrap");
   hw_force_a: assert property ( // [R6]
      (rd_hit && opt_in.hw_activation) |=> rdata_out[0])
      else $error("hardware activation not forced");
   sticky_activate_a: assert property ( // [R7]
      activate |=> activate)
      else $error("activation cleared by software");
   timer_mode_a: assert property ( // [R8]
      (!active && !wr_hit && step && count == 7'h40) |=> !wdg_reset_out && count == 7'h3f)
      else $error("timer mode misbehaved");
   first_step_a: assert property ( // [R9]
      (wr_hit && bus_req_in.wdata[0] && !active) |=> presc == 12'h000 ##1 presc == 12'h001)
      else $error("prescaler not restarted on activation");
   no_wake_a: assert property ( // [R12]
      (pwr != PWR_RUN && !global_irq_enable_in) |=> pwr == $past(pwr))
      else $error("woke with interrupts disabled");
   stop_as_wait_a: assert property ( // [R14]
      (pwr == PWR_RUN && stop_instr_in && opt_in.hw_activation && !opt_in.ext_stop_ctrl)
      |=> pwr == PWR_WAIT)
      else $error("stop not taken as wait");
   stop_freeze_a: assert property ( // [R15]
      (pwr == PWR_STOP && !wr_hit) |=> $stable(count) && $stable(presc))
      else $error("counter moved in stop");

   cover_write_reset_c: cover property (fall_by_write ##1 wdg_reset_out);
   cover_timeout_c:     cover property (fall_by_count ##1 wdg_reset_out);
   cover_stop_wake_c:   cover property (pwr == PWR_STOP ##1 pwr == PWR_RUN);
   cover_wait_c:        cover property (pwr == PWR_WAIT);
endmodule

// ===== tb_top.sv
// Self-checking bench for the watchdog downcounter and its register.
// Assumes the bench plays the core; reset requests are checked, not looped back.
module tb_top
   import wdg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic         clk_sys_in = 1'b0;
   logic         rst_n_in = 1'b0;
   wdg_bus_req_s bus_req_in = '0;
   wdg_opt_s     opt_in = '0;
   logic         nmi_pin_in = 1'b0, nmi_req_in = 1'b0, irq_req_in = 1'b0;
   logic         global_irq_enable_in = 1'b0, stop_instr_in = 1'b0, wait_instr_in = 1'b0;
   logic [7:0]   rdata_out, got;
   logic         wdg_reset_out, stop_mode_out, wait_mode_out, wake_out, nmi_service_out;
   int           n_mismatch = 0, tests_run = 0, cycles = 0, n;
   // Rows: written image, then expected read-back image.
   logic [15:0]  rows [5] = '{16'h8282, 16'hfefe, 16'h7e7e, 16'h5656, 16'h0303};
   // Rows: hardware option, stop control, pin level, then expected stop and wait flags.
   logic [4:0]   pwr [4] = '{5'b00010, 5'b10101, 5'b11110, 5'b11001};

   wdg_downcounter dut (.clk_sys_in, .rst_n_in, .bus_req_in, .opt_in, .nmi_pin_in,
      .nmi_req_in, .irq_req_in, .global_irq_enable_in, .stop_instr_in, .wait_instr_in,
      .rdata_out, .wdg_reset_out, .stop_mode_out, .wait_mode_out, .wake_out,
      .nmi_service_out);

   // Free-running oscillator clock, 8 ns period.
   always #4 clk_sys_in = ~clk_sys_in;

   // Cuts a hung run short; the longest wait is well under this ceiling.
   always @(posedge clk_sys_in) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_mismatch++;
         finish_test();
      end
   end

   task automatic chk_n(input int g, input int e);
      tests_run++;
      if (g != e) begin
         n_mismatch++;
         $display("Error at %0t: count %0d expected %0d", $time, g, e);
      end
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      chk8({7'h00, g}, {7'h00, e});
   endtask
   task automatic do_reset();
      @(posedge clk_sys_in) rst_n_in <= 1'b0;
      repeat (8) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      @(posedge clk_sys_in);
   endtask
   // One register access: strobe held for one edge, settled values seen after it.
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in) bus_req_in <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk_sys_in) bus_req_in <= '0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      access(1'b0, a, 8'h00);
      got = rdata_out;
   endtask
   // Counts edges until a reset request shows, giving up after lim edges.
   task automatic wait_rst(input int lim);
      n = 0;
      while (wdg_reset_out !== 1'b1 && n < lim) begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end
   endtask
   task automatic pulse(input logic s);
      @(posedge clk_sys_in) begin stop_instr_in <= s; wait_instr_in <= !s; end
      @(posedge clk_sys_in) begin stop_instr_in <= 1'b0; wait_instr_in <= 1'b0; end
      #1;
   endtask
   task automatic finish_test();
      $display("Mismatches %0d of %0d checks", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // Main sequence: register table rows, then timeouts, options and power states.
   initial begin
      do_reset();
      rd(WDG_COUNT_CONTROL_ADDR);
      chk8(got, WDG_RESET_IMAGE);
      foreach (rows[i]) begin
         do_reset();
         access(1'b1, WDG_COUNT_CONTROL_ADDR, rows[i][15:8]);
         rd(WDG_COUNT_CONTROL_ADDR);
         chk8(got, rows[i][7:0]);
      end
      access(1'b1, WDG_COUNT_CONTROL_ADDR, 8'h02);
      rd(WDG_COUNT_CONTROL_ADDR);
      chk8(got, 8'h03);
      for (int t = 0; t < 2; t++) begin
         do_reset();
         access(1'b1, WDG_COUNT_CONTROL_ADDR, {t[0], 7'h03});
         wait_rst(8000);
         chk_n(n, (t + 1) * WDG_STEP_CYCLES);
      end
      // Start-up guard write: clearing the soft-reset bit resets at once.
      do_reset();
      access(1'b1, WDG_COUNT_CONTROL_ADDR, 8'hfd);
      wait_rst(3);
      chk1(wdg_reset_out, 1'b1);
      // A write elsewhere leaves the register alone; reads elsewhere give zero.
      do_reset();
      access(1'b1, 8'hd9, 8'h00);
      rd(WDG_COUNT_CONTROL_ADDR);
      chk8(got, WDG_RESET_IMAGE);
      rd(8'hd9);
      chk8(got, WDG_UNMAPPED_READ);
      access(1'b1, WDG_COUNT_CONTROL_ADDR, 8'h02);
      wait_rst(WDG_STEP_CYCLES);
      chk1(wdg_reset_out, 1'b0);
      rd(WDG_COUNT_CONTROL_ADDR);
      chk8(got, 8'hfc);
      @(posedge clk_sys_in) opt_in <= '{hw_activation: 1'b1, ext_stop_ctrl: 1'b0};
      do_reset();
      access(1'b1, WDG_COUNT_CONTROL_ADDR, 8'hfe);
      rd(WDG_COUNT_CONTROL_ADDR);
      chk8(got, 8'hff);
      // A reload about a third of the way into a prescaler period still gives the full shortest period.
      repeat (1000) @(posedge clk_sys_in);
      access(1'b1, WDG_COUNT_CONTROL_ADDR, 8'h02);
      wait_rst(4000);
      chk_n(n, WDG_STEP_CYCLES);
      foreach (pwr[i]) begin
         @(posedge clk_sys_in) begin opt_in <= pwr[i][4:3]; nmi_pin_in <= pwr[i][2]; end
         do_reset();
         pulse(1'b1);
         chk1(stop_mode_out, pwr[i][1]);
         chk1(wait_mode_out, pwr[i][0]);
         @(posedge clk_sys_in) begin irq_req_in <= 1'b1; nmi_req_in <= 1'b1; end
         repeat (2) @(posedge clk_sys_in);
         #1;
         chk1(wake_out, 1'b0);
         chk1(stop_mode_out, pwr[i][1]);
         chk1(nmi_service_out, 1'b0);
         @(posedge clk_sys_in) global_irq_enable_in <= 1'b1;
         #1;
         chk1(wake_out, 1'b1);
         @(posedge clk_sys_in) begin irq_req_in <= 1'b0; nmi_req_in <= 1'b0; end
         global_irq_enable_in <= 1'b0;
         #1;
         chk1(stop_mode_out | wait_mode_out, 1'b0);
      end
      // Counter must stand still across a long stop and resume afterwards.
      @(posedge clk_sys_in) opt_in <= '0;
      do_reset();
      pulse(1'b1);
      repeat (3100) @(posedge clk_sys_in);
      @(posedge clk_sys_in) begin irq_req_in <= 1'b1; global_irq_enable_in <= 1'b1; end
      @(posedge clk_sys_in) begin irq_req_in <= 1'b0; global_irq_enable_in <= 1'b0; end
      rd(WDG_COUNT_CONTROL_ADDR);
      chk8(got, WDG_RESET_IMAGE);
      // One full step after the wake the counter has moved down by one.
      repeat (3072) @(posedge clk_sys_in);
      rd(WDG_COUNT_CONTROL_ADDR);
      chk8(got, 8'h7e);
      @(posedge clk_sys_in) nmi_req_in <= 1'b1;
      #1;
      chk1(nmi_service_out, 1'b1);
      @(posedge clk_sys_in) nmi_req_in <= 1'b0;
      pulse(1'b0);
      chk1(wait_mode_out, 1'b1);
      finish_test();
   end
endmodule
